// ### rtl/phs_pkg.sv
// port handshake block: shared constants for both ends and the link
// assumes one clock and one active-low asynchronous reset everywhere
package phs_pkg;

  // widths
  localparam int DATA_W_DEF    = 32;
  localparam int ADDR_W        = 8;
  localparam int RUN_CNT_W     = 16;
  localparam int ACK_DLY_W_DEF = 4;

  // controller register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ARG_A   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ARG_B   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ARG_C   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ARG_D   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ARG_E   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SUM     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PROD    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CNT     = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_E_OUT   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_ACK_DLY = 8'h30;

  // field positions
  localparam int CTRL_START_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_IDLE_BIT   = 2;

  // arithmetic steps
  localparam int CNT_STEP = 1;
  localparam int RUN_STEP = 1;
  localparam int DLY_STEP = 1;

endpackage : phs_pkg

// ### rtl/phs_if.sv
// port handshake block: link between the function block and its partner
// assumes both ends sit on the same clock; no clocking is done here
`timescale 1ns/1ns
interface phs_if #(
  parameter int W = phs_pkg::DATA_W_DEF
);
  // run control
  logic         run_request;
  logic         run_complete;
  logic         waiting_indicator;
  logic         inputs_consumed;
  logic [W-1:0] result_port;
  // bare data input and inout split
  logic [W-1:0] arg_a;
  logic [W-1:0] arg_e_i;
  logic [W-1:0] arg_e_o;
  logic         arg_e_o_valid;
  // valid-only input
  logic [W-1:0] arg_b;
  logic         arg_b_valid;
  // two-way handshake input
  logic [W-1:0] arg_c;
  logic         arg_c_valid;
  logic         arg_c_ack;
  // acknowledge-only input
  logic [W-1:0] arg_d;
  logic         arg_d_ack;
  // valid-only output
  logic [W-1:0] sum;
  logic         sum_output_valid;
  // two-way handshake output
  logic [W-1:0] prod;
  logic         prod_valid;
  logic         prod_ack;
  // acknowledge-only output
  logic [W-1:0] cnt;
  logic         cnt_ack;

  modport dev (
    input  run_request, arg_a, arg_e_i, arg_b, arg_b_valid,
    input  arg_c, arg_c_valid, arg_d, prod_ack, cnt_ack,
    output run_complete, waiting_indicator, inputs_consumed, result_port,
    output arg_e_o, arg_e_o_valid, arg_c_ack, arg_d_ack,
    output sum, sum_output_valid, prod, prod_valid, cnt
  );

  modport host (
    output run_request, arg_a, arg_e_i, arg_b, arg_b_valid,
    output arg_c, arg_c_valid, arg_d, prod_ack, cnt_ack,
    input  run_complete, waiting_indicator, inputs_consumed, result_port,
    input  arg_e_o, arg_e_o_valid, arg_c_ack, arg_d_ack,
    input  sum, sum_output_valid, prod, prod_valid, cnt
  );
endinterface : phs_if

// ### rtl/phs_device.sv
// port handshake block: the function block end of the link
// assumes the partner keeps bare inputs steady during a run and that
// every link input is synchronous to ref_clk_in
`timescale 1ns/1ns

// Functional notes
// - producer holds bare inputs until taken
// - each output but the ack-only cnt and result_port carries its own valid
// - read-write argument split into two ports
// - result valid when run completes
// - run starts only on run request
// - waiting indicator low while running
// - inputs read after first cycle, then consumed
// - waiting indicator high again after completion
// - bare port is data alone
// - producer holds bare data until consumed
// - consumer reads bare output before next run
// - handshake input stalls until valid
// - handshake input acknowledges taken data
// - handshake output valid with its data
// - handshake output stalls until acknowledge
// - handshake output valid drops after acknowledge
// - ack-only input acknowledge in read cycle
// - ack-only output stalls until acknowledge
// - valid-only input captured at once, held
// - valid-only output gives a valid
// - inout: bare input half, valid output half
// - control names extend data port names
module phs_device #(
  parameter int W = phs_pkg::DATA_W_DEF
) (
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  // link to the partner
  phs_if.dev                              bus,
  // user side
  output logic [phs_pkg::RUN_CNT_W-1:0]   run_count_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_HS_IN, ST_ACK_IN,
    ST_OUT_SUM, ST_OUT_HS, ST_OUT_ACK, ST_DONE
  } phs_dev_state_e;

  typedef struct packed {
    phs_dev_state_e                 st;
    logic [W-1:0]                   a_lat;
    logic [W-1:0]                   b_hold;
    logic                           b_have;
    logic [W-1:0]                   b_use;
    logic [W-1:0]                   c_lat;
    logic [W-1:0]                   d_lat;
    logic [W-1:0]                   e_lat;
    logic                           waiting;
    logic                           consumed;
    logic                           c_ack;
    logic                           d_ack;
    logic [W-1:0]                   sum;
    logic                           sum_vld;
    logic [W-1:0]                   e_o;
    logic                           e_o_vld;
    logic [W-1:0]                   prod;
    logic                           prod_vld;
    logic [W-1:0]                   cnt;
    logic                           done;
    logic [W-1:0]                   result;
    logic [phs_pkg::RUN_CNT_W-1:0]  runs;
  } phs_dev_s;

  phs_dev_s s_q;
  phs_dev_s s_d;

  // wrap-around add at data width
  function automatic logic [W-1:0] phs_add(input logic [W-1:0] x,
                                           input logic [W-1:0] y);
    phs_add = x + y;
  endfunction : phs_add

  // low half of the product; the high half is dropped on purpose
  function automatic logic [W-1:0] phs_mul(input logic [W-1:0] x,
                                           input logic [W-1:0] y);
    logic [2*W-1:0] p;
    p = x * y;
    phs_mul = p[W-1:0];
  endfunction : phs_mul

  // next-state logic; pulses other than d_ack default low every cycle
  always_comb begin
    s_d          = s_q;
    s_d.consumed = 1'b0;
    s_d.c_ack    = 1'b0;
    s_d.sum_vld  = 1'b0;
    s_d.e_o_vld  = 1'b0;
    s_d.done     = 1'b0;
    // valid-only input is caught whatever state we are in
    if (bus.arg_b_valid) begin
      s_d.b_hold = bus.arg_b;
      s_d.b_have = 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.waiting = 1'b1;
        if (bus.run_request) begin
          s_d.waiting = 1'b0;
          s_d.st      = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // bare ports: sampled no sooner than the second run cycle
        s_d.a_lat = bus.arg_a;
        s_d.e_lat = bus.arg_e_i;
        if (s_q.b_have) begin
          s_d.b_use  = s_q.b_hold;
          // a fresh valid in this cycle is kept for the next run
          s_d.b_have = bus.arg_b_valid;
          s_d.st     = ST_HS_IN;
        end
      end
      ST_HS_IN: begin
        // stay here while the producer has nothing to offer
        if (bus.arg_c_valid) begin
          s_d.c_lat = bus.arg_c;
          s_d.c_ack = 1'b1;
          s_d.d_ack = 1'b1;
          s_d.st    = ST_ACK_IN;
        end
      end
      ST_ACK_IN: begin
        // acknowledge stands in exactly this reading cycle
        s_d.d_lat    = bus.arg_d;
        s_d.d_ack    = 1'b0;
        s_d.consumed = 1'b1;
        s_d.st       = ST_OUT_SUM;
      end
      ST_OUT_SUM: begin
        s_d.sum      = phs_add(s_q.a_lat, s_q.b_use);
        s_d.sum_vld  = 1'b1;
        s_d.e_o      = phs_add(s_q.e_lat, s_q.a_lat);
        s_d.e_o_vld  = 1'b1;
        s_d.prod     = phs_mul(s_q.c_lat, s_q.d_lat);
        s_d.prod_vld = 1'b1;
        s_d.st       = ST_OUT_HS;
      end
      ST_OUT_HS: begin
        if (bus.prod_ack) begin
          s_d.prod_vld = 1'b0;
          s_d.cnt      = phs_add(s_q.d_lat, W'(phs_pkg::CNT_STEP));
          s_d.st       = ST_OUT_ACK;
        end
      end
      ST_OUT_ACK: begin
        // no valid here; consumer acks when it has read cnt
        if (bus.cnt_ack) begin
          s_d.done   = 1'b1;
          s_d.result = phs_add(phs_add(s_q.a_lat, s_q.b_use),
                               phs_add(s_q.c_lat, s_q.d_lat));
          s_d.runs   = s_q.runs +
                       phs_pkg::RUN_CNT_W'(phs_pkg::RUN_STEP);
          s_d.st     = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.waiting = 1'b1;
        s_d.st      = ST_IDLE;
      end
    endcase
  end

  // state register; every control comes out of reset low
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // link outputs come straight from the state register
  // bare ports have no companion signals at all
  assign bus.waiting_indicator = s_q.waiting;
  assign bus.inputs_consumed   = s_q.consumed;
  assign bus.run_complete      = s_q.done;
  assign bus.result_port       = s_q.result;
  assign bus.arg_c_ack         = s_q.c_ack;
  assign bus.arg_d_ack         = s_q.d_ack;
  assign bus.sum               = s_q.sum;
  assign bus.sum_output_valid  = s_q.sum_vld;
  assign bus.arg_e_o           = s_q.e_o;
  assign bus.arg_e_o_valid     = s_q.e_o_vld;
  assign bus.prod              = s_q.prod;
  assign bus.prod_valid        = s_q.prod_vld;
  assign bus.cnt               = s_q.cnt;
  assign run_count_out         = s_q.runs;

endmodule : phs_device

// ### rtl/phs_host.sv
// port handshake block: producer and consumer end of the link
// assumes a simple register port driven by software on ref_clk_in
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module phs_host #(
  parameter int W         = phs_pkg::DATA_W_DEF,
  parameter int ACK_DLY_W = phs_pkg::ACK_DLY_W_DEF
) (
  // clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_n_in,
  // link to the function block
  phs_if.host                            bus,
  // register port
  input  wire logic [phs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [W-1:0]              wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [W-1:0]              rdata_out
);

  typedef struct packed {
    logic                 run;
    logic                 req;
    logic [W-1:0]         a;
    logic [W-1:0]         b;
    logic [W-1:0]         c;
    logic [W-1:0]         d;
    logic [W-1:0]         e;
    logic                 b_vld;
    logic                 c_vld;
    logic                 prod_ack;
    logic                 prod_done;
    logic                 cnt_ack;
    logic [ACK_DLY_W-1:0] dly;
    logic [ACK_DLY_W-1:0] ack_dly;
    logic [W-1:0]         result;
    logic [W-1:0]         sum;
    logic [W-1:0]         prod;
    logic [W-1:0]         cnt;
    logic [W-1:0]         e_o;
    logic                 done;
    logic [W-1:0]         rdata;
  } phs_host_s;

  phs_host_s s_q;
  phs_host_s s_d;

  // next-state logic
  always_comb begin
    s_d          = s_q;
    s_d.rdata    = '0;
    s_d.b_vld    = 1'b0;
    s_d.prod_ack = 1'b0;
    // run request held until the block shows it has left waiting
    if (s_q.req && !bus.waiting_indicator) begin
      s_d.req = 1'b0;
    end
    if (s_q.c_vld && bus.arg_c_ack) begin
      s_d.c_vld = 1'b0;
    end
    // valid-only outputs: take whenever marked
    if (bus.sum_output_valid) begin
      s_d.sum = bus.sum;
    end
    if (bus.arg_e_o_valid) begin
      s_d.e_o = bus.arg_e_o;
    end
    // handshake output: ack after a programmable delay, one pulse
    if (bus.prod_valid && !s_q.prod_ack) begin
      if (s_q.dly == s_q.ack_dly) begin
        s_d.prod_ack  = 1'b1;
        s_d.prod      = bus.prod;
        s_d.prod_done = 1'b1;
        s_d.dly       = '0;
      end else begin
        s_d.dly = s_q.dly + ACK_DLY_W'(phs_pkg::DLY_STEP);
      end
    end
    // ack-only output: level ack held until the run completes
    if (s_q.prod_done && !s_q.cnt_ack) begin
      if (s_q.dly == s_q.ack_dly) begin
        s_d.cnt_ack = 1'b1;
      end else begin
        s_d.dly = s_q.dly + ACK_DLY_W'(phs_pkg::DLY_STEP);
      end
    end
    // register writes; argument values are frozen during a run
    if (wr_in) begin
      unique case (addr_in)
        phs_pkg::OFS_CTRL: begin
          if (wdata_in[phs_pkg::CTRL_START_BIT] && !s_q.run) begin
            s_d.run       = 1'b1;
            s_d.req       = 1'b1;
            s_d.b_vld     = 1'b1;
            s_d.c_vld     = 1'b1;
            s_d.prod_done = 1'b0;
            s_d.cnt_ack   = 1'b0;
            s_d.dly       = '0;
            s_d.done      = 1'b0;
          end
        end
        phs_pkg::OFS_ARG_A: if (!s_q.run) s_d.a = wdata_in;
        phs_pkg::OFS_ARG_B: if (!s_q.run) s_d.b = wdata_in;
        phs_pkg::OFS_ARG_C: if (!s_q.run) s_d.c = wdata_in;
        phs_pkg::OFS_ARG_D: if (!s_q.run) s_d.d = wdata_in;
        phs_pkg::OFS_ARG_E: if (!s_q.run) s_d.e = wdata_in;
        phs_pkg::OFS_ACK_DLY: s_d.ack_dly = wdata_in[ACK_DLY_W-1:0];
        default: begin
        end
      endcase
    end
    // completion last so its set wins over a same-cycle clear
    if (bus.run_complete) begin
      s_d.result    = bus.result_port;
      s_d.cnt       = bus.cnt;
      s_d.run       = 1'b0;
      s_d.cnt_ack   = 1'b0;
      s_d.prod_done = 1'b0;
      s_d.done      = 1'b1;
    end
    // register reads, answered in the next cycle only
    if (rd_in) begin
      unique case (addr_in)
        phs_pkg::OFS_ARG_A:   s_d.rdata = s_q.a;
        phs_pkg::OFS_ARG_B:   s_d.rdata = s_q.b;
        phs_pkg::OFS_ARG_C:   s_d.rdata = s_q.c;
        phs_pkg::OFS_ARG_D:   s_d.rdata = s_q.d;
        phs_pkg::OFS_ARG_E:   s_d.rdata = s_q.e;
        phs_pkg::OFS_RESULT:  s_d.rdata = s_q.result;
        phs_pkg::OFS_SUM:     s_d.rdata = s_q.sum;
        phs_pkg::OFS_PROD:    s_d.rdata = s_q.prod;
        phs_pkg::OFS_CNT:     s_d.rdata = s_q.cnt;
        phs_pkg::OFS_E_OUT:   s_d.rdata = s_q.e_o;
        phs_pkg::OFS_ACK_DLY: s_d.rdata = W'(s_q.ack_dly);
        phs_pkg::OFS_STATUS: begin
          s_d.rdata[phs_pkg::STAT_BUSY_BIT] = s_q.run;
          s_d.rdata[phs_pkg::STAT_DONE_BIT] = s_q.done;
          s_d.rdata[phs_pkg::STAT_IDLE_BIT] = bus.waiting_indicator;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  // state register; all controls low in reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // link and port outputs straight from the register
  assign bus.run_request = s_q.req;
  assign bus.arg_a       = s_q.a;
  assign bus.arg_b       = s_q.b;
  assign bus.arg_b_valid = s_q.b_vld;
  assign bus.arg_c       = s_q.c;
  assign bus.arg_c_valid = s_q.c_vld;
  assign bus.arg_d       = s_q.d;
  assign bus.arg_e_i     = s_q.e;
  assign bus.prod_ack    = s_q.prod_ack;
  assign bus.cnt_ack     = s_q.cnt_ack;
  assign rdata_out       = s_q.rdata;

endmodule : phs_host

// ### dv/phs_monitor.sv
// port handshake block: concurrent checks on the run and handshake link
// assumes the plain signals of phs_if, all sampled on ref_clk_in
`timescale 1ns/1ns
module phs_monitor #(
  parameter int W = phs_pkg::DATA_W_DEF
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  // run control
  input  wire logic         run_request,
  input  wire logic         run_complete,
  input  wire logic         waiting_indicator,
  input  wire logic         inputs_consumed,
  // input handshakes
  input  wire logic         arg_c_valid,
  input  wire logic         arg_c_ack,
  input  wire logic         arg_d_ack,
  // output handshakes
  input  wire logic         arg_e_o_valid,
  input  wire logic         sum_output_valid,
  input  wire logic [W-1:0] prod,
  input  wire logic         prod_valid,
  input  wire logic         prod_ack,
  input  wire logic         cnt_ack
);
  // one domain, so clock and reset are given once
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // run control
  AST_START_LEAVES_IDLE: assert property (
    waiting_indicator && run_request |=> !waiting_indicator)
    else $error("idle indication stayed high after a run request");
  AST_NO_REQUEST_STAYS_IDLE: assert property (
    waiting_indicator && !run_request |=> waiting_indicator)
    else $error("run began without a run request");
  AST_IDLE_AFTER_COMPLETE: assert property (
    run_complete |-> !waiting_indicator ##1 waiting_indicator)
    else $error("idle indication not raised after completion");
  AST_CONSUMED_PULSE: assert property (
    inputs_consumed |-> !waiting_indicator ##1 !inputs_consumed)
    else $error("inputs consumed is not a pulse within a run");
  // input handshakes: arg_c_ack only for valid taken the edge before; arg_d_ack followed by consumed
  AST_HS_IN_ACK: assert property (
    arg_c_ack |-> $past(arg_c_valid))
    else $error("handshake input acknowledged without valid");
  AST_ACK_ONLY_IN: assert property (
    arg_d_ack |=> inputs_consumed && !arg_d_ack)
    else $error("ack-only input read not followed by consumed");
  // output handshakes
  AST_HS_OUT_WITH_SUM: assert property (
    $rose(prod_valid) |-> sum_output_valid && arg_e_o_valid)
    else $error("output valids did not rise together");
  AST_HS_OUT_DATA_HELD: assert property (
    prod_valid && $past(prod_valid) |-> $stable(prod))
    else $error("handshake output data moved while valid");
  AST_HS_OUT_STALL: assert property (
    prod_valid && !prod_ack |=> prod_valid)
    else $error("handshake output valid dropped without ack");
  AST_HS_OUT_DROP: assert property (
    prod_valid && prod_ack |=> !prod_valid)
    else $error("handshake output valid held after ack");
  AST_ACK_ONLY_OUT: assert property (
    run_complete |-> $past(cnt_ack))
    else $error("run completed before ack-only output was taken");
endmodule : phs_monitor

// ### dv/tb.sv
// port handshake block: testbench joining host and device over phs_if
// assumes software-style register access on the host register port
`timescale 1ns/1ns
module tb;
  localparam int W = phs_pkg::DATA_W_DEF;

  // clock, reset and register port
  logic                       ref_clk_in;
  logic                       rst_n_in;
  logic [phs_pkg::ADDR_W-1:0] addr;
  logic [W-1:0]               wdata;
  logic                       wr;
  logic                       rd;
  logic [W-1:0]               rdata;
  logic [phs_pkg::RUN_CNT_W-1:0] run_count;
  // bookkeeping
  int                         fails;
  int                         samples_checked;
  int                         runs;
  int                         done_seen;
  int                         consumed_seen;
  int                         d_ack_seen;

  phs_if #(.W(W)) bus ();

  phs_device #(.W(W)) phs_device_inst (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .bus           (bus),
    .run_count_out (run_count)
  );

  phs_host #(.W(W), .ACK_DLY_W(phs_pkg::ACK_DLY_W_DEF)) phs_host_inst (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .bus        (bus),
    .addr_in    (addr),
    .wdata_in   (wdata),
    .wr_in      (wr),
    .rd_in      (rd),
    .rdata_out  (rdata)
  );

  phs_monitor #(.W(W)) phs_monitor_inst (
    .ref_clk_in        (ref_clk_in),
    .rst_n_in          (rst_n_in),
    .run_request       (bus.run_request),
    .run_complete      (bus.run_complete),
    .waiting_indicator (bus.waiting_indicator),
    .inputs_consumed   (bus.inputs_consumed),
    .arg_c_valid       (bus.arg_c_valid),
    .arg_c_ack         (bus.arg_c_ack),
    .arg_d_ack         (bus.arg_d_ack),
    .arg_e_o_valid     (bus.arg_e_o_valid),
    .sum_output_valid  (bus.sum_output_valid),
    .prod              (bus.prod),
    .prod_valid        (bus.prod_valid),
    .prod_ack          (bus.prod_ack),
    .cnt_ack           (bus.cnt_ack)
  );

  // clock
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // pulse counters on the link, checked against completed runs
  always @(posedge ref_clk_in) begin
    if (bus.run_complete === 1'b1) done_seen++;
    if (bus.inputs_consumed === 1'b1) consumed_seen++;
    if (bus.arg_d_ack === 1'b1) d_ack_seen++;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-cycle write strobe
  task automatic reg_wr(input logic [phs_pkg::ADDR_W-1:0] a,
                        input logic [W-1:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr    <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [phs_pkg::ADDR_W-1:0] a,
                        output logic [W-1:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // one full run; stray writes while busy must not disturb it
  task automatic run_one(input logic [W-1:0] a, b, c, d, e,
                         input logic [W-1:0] dly);
    logic [W-1:0] v;
    logic [W-1:0] st;
    int           k;
    reg_wr(phs_pkg::OFS_ARG_A, a);
    reg_wr(phs_pkg::OFS_ARG_B, b);
    reg_wr(phs_pkg::OFS_ARG_C, c);
    reg_wr(phs_pkg::OFS_ARG_D, d);
    reg_wr(phs_pkg::OFS_ARG_E, e);
    reg_wr(phs_pkg::OFS_ACK_DLY, dly);
    reg_wr(phs_pkg::OFS_CTRL, 32'h00000001);
    reg_wr(phs_pkg::OFS_ARG_A, ~a);
    reg_wr(phs_pkg::OFS_CTRL, 32'h00000001);
    runs++;
    v = '0;
    k = 0;
    while (v[phs_pkg::STAT_DONE_BIT] !== 1'b1 && k < 100) begin
      reg_rd(phs_pkg::OFS_STATUS, v);
      k++;
    end
    if (v[phs_pkg::STAT_DONE_BIT] !== 1'b1) begin
      fails++;
      finish_test();
    end
    st = '0;
    st[phs_pkg::STAT_DONE_BIT] = 1'b1;
    st[phs_pkg::STAT_IDLE_BIT] = 1'b1;
    reg_rd(phs_pkg::OFS_STATUS, v);
    check("status", v, st);
    reg_rd(phs_pkg::OFS_RESULT, v);
    check("result", v, a + b + c + d);
    reg_rd(phs_pkg::OFS_SUM, v);
    check("sum", v, a + b);
    reg_rd(phs_pkg::OFS_PROD, v);
    check("prod", v, c * d);
    reg_rd(phs_pkg::OFS_CNT, v);
    check("cnt", v, d + 32'h00000001);
    reg_rd(phs_pkg::OFS_E_OUT, v);
    check("e_out", v, e + a);
    check("run_count", W'(run_count), W'(runs));
    check("done_pulses", W'(done_seen), W'(runs));
    check("consumed_pulses", W'(consumed_seen), W'(runs));
    check("d_ack_pulses", W'(d_ack_seen), W'(runs));
  endtask : run_one

  // main sequence
  initial begin
    logic [W-1:0] v;
    logic [W-1:0] st;
    rst_n_in = 1'b0;
    addr     = '0;
    wdata    = '0;
    wr       = 1'b0;
    rd       = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    st = '0;
    st[phs_pkg::STAT_IDLE_BIT] = 1'b1;
    reg_rd(phs_pkg::OFS_STATUS, v);
    check("status_reset", v, st);
    reg_rd(phs_pkg::OFS_RESULT, v);
    check("result_reset", v, 32'h00000000);
    reg_wr(8'h40, 32'hFFFFFFFF);
    reg_rd(8'h40, v);
    check("unmapped", v, 32'h00000000);
    // back-to-back runs, shortest to longest consumer delay
    run_one(32'h00000001, 32'h00000002, 32'h00000003, 32'h00000004,
            32'h00000005, 32'h00000000);
    run_one(32'hFFFFFFFF, 32'h00000001, 32'h00010000, 32'h00010001,
            32'h00000007, 32'h00000003);
    run_one(32'h12345678, 32'h9ABCDEF0, 32'hFFFFFFFE, 32'hFFFFFFFF,
            32'hFFFFFFFF, 32'h0000000F);
    finish_test();
  end
endmodule : tb
